// ==== verilog/lcd_seg_slave.sv ====
// Two-wire write-only slave that loads a control byte and eight
// segment bytes, and maps them onto segment and backplane outputs.
// Assumes the bus pins and subaddress pins are asynchronous to clk.
`timescale 1ns/10ps
`include "lcd_seg_params.svh"

module lcd_seg_slave #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [2:0] hardwareSubaddressPins,
    input wire logic cascadeMode,
    output logic [32:1] segmentOutputs,
    output logic firstBackplane,
    output logic firstBackplaneOe,
    output logic secondBackplane,
    output logic secondBackplaneOe,
    output logic driveMode,
    output logic bankSelect,
    output logic [5:0] segmentBytePointer,
    output logic busBusy
);
    // Reset release through two flops
    logic rstMeta_reg;
    logic rstn;
    // Input synchronisers, three stages each
    logic [2:0] sclSync_reg, sdaSync_reg;
    logic [2:0] subA_reg, subB_reg, subC_reg;
    logic sclLvl_reg, sdaLvl_reg;
    logic [2:0] subLvl_reg;
    // Filtered level next values
    logic sclLvl_next, sdaLvl_next;
    // Bus events
    logic sclRise, sclFall, startCond, stopCond;
    // Receive engine
    lcd_seg_pkg::phase_t phase_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic ackSlot_reg;
    logic ackDrive_reg;
    logic [7:0] ctrl_reg;
    logic [5:0] ptr_reg;
    // Completed byte, sampled on eighth rise
    logic [7:0] byteNext;
    logic ptrMatch;
    // Segment storage
    logic [7:0] segReg_reg [8];
    // FIFO between receiver and register file
    logic fifoInValid, fifoInReady, fifoOutValid;
    logic [13:0] fifoInData, fifoOutData;
    logic [2:0] wrIndex;

    // Reset synchroniser
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta_reg <= 1'b0;
            rstn <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstn <= rstMeta_reg;
        end
    end

    // Three-flop samplers; idle bus reads high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
        end
        else if (clkEn)
        begin
            sclSync_reg <= {sclSync_reg[1:0], sclIn};
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
        end
    end

    // Subaddress pins, one sampler per bit
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sub
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    subA_reg[gi] <= 1'b0;
                    subB_reg[gi] <= 1'b0;
                    subC_reg[gi] <= 1'b0;
                    subLvl_reg[gi] <= 1'b0;
                end
                else if (clkEn)
                begin
                    subA_reg[gi] <= hardwareSubaddressPins[gi];
                    subB_reg[gi] <= subA_reg[gi];
                    subC_reg[gi] <= subB_reg[gi];
                    // Change accepted when stages two and three agree
                    if (subB_reg[gi] == subC_reg[gi])
                        subLvl_reg[gi] <= subC_reg[gi];
                end
            end
        end
    endgenerate

    // Level changes only when last two stages agree
    always_comb
    begin
        sclLvl_next = sclLvl_reg;
        sdaLvl_next = sdaLvl_reg;
        if (sclSync_reg[1] == sclSync_reg[2])
            sclLvl_next = sclSync_reg[2];
        if (sdaSync_reg[1] == sdaSync_reg[2])
            sdaLvl_next = sdaSync_reg[2];
    end

    // Filtered levels
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclLvl_reg <= 1'b1;
            sdaLvl_reg <= 1'b1;
        end
        else if (clkEn)
        begin
            sclLvl_reg <= sclLvl_next;
            sdaLvl_reg <= sdaLvl_next;
        end
    end

    assign sclRise = !sclLvl_reg && sclLvl_next;
    assign sclFall = sclLvl_reg && !sclLvl_next;
    assign startCond = sclLvl_reg && sclLvl_next && sdaLvl_reg && !sdaLvl_next;
    assign stopCond = sclLvl_reg && sclLvl_next && !sdaLvl_reg && sdaLvl_next;
    // MSB first, shifted in on rise
    assign byteNext = {shift_reg[6:0], sdaLvl_next};

    // match upper pointer bits; duplex drops top bit
    assign ptrMatch = (ptr_reg[4:3] == subLvl_reg[1:0]) &&
                      (ctrl_reg[`LCD_CTRL_MODE_BIT] || (ptr_reg[5] == subLvl_reg[2]));

    // Bit counter and shifter; SCL falls move to next slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ackSlot_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            if (startCond || stopCond)
            begin
                bitCnt_reg <= 4'h0;
                ackSlot_reg <= 1'b0;
            end
            else if (sclRise && !ackSlot_reg)
            begin
                shift_reg <= byteNext;
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            else if (sclFall)
            begin
                // Ninth pulse follows the eighth bit
                if (bitCnt_reg == `LCD_BITS_PER_BYTE && !ackSlot_reg)
                    ackSlot_reg <= 1'b1;
                else if (ackSlot_reg)
                begin
                    ackSlot_reg <= 1'b0;
                    bitCnt_reg <= 4'h0;
                end
            end
        end
    end

    // Byte phase tracking and ack decision
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_reg <= lcd_seg_pkg::PH_IDLE;
            ackDrive_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            if (stopCond)
            begin
                phase_reg <= lcd_seg_pkg::PH_IDLE;
                ackDrive_reg <= 1'b0;
            end
            else if (startCond)
            begin
                phase_reg <= lcd_seg_pkg::PH_ADDR;
                ackDrive_reg <= 1'b0;
            end
            else if (sclRise && !ackSlot_reg && bitCnt_reg == 4'h7)
            begin
                unique case (phase_reg)
                    lcd_seg_pkg::PH_IDLE:
                        ackDrive_reg <= 1'b0;
                    lcd_seg_pkg::PH_ADDR:
                    begin
                        ackDrive_reg <= (byteNext == `LCD_SLAVE_ADDR);
                        phase_reg <= (byteNext == `LCD_SLAVE_ADDR) ?
                                     lcd_seg_pkg::PH_CTRL : lcd_seg_pkg::PH_IDLE;
                    end
                    lcd_seg_pkg::PH_CTRL:
                    begin
                        ackDrive_reg <= 1'b1;
                        phase_reg <= lcd_seg_pkg::PH_DATA;
                    end
                    lcd_seg_pkg::PH_DATA:
                        ackDrive_reg <= ptrMatch && fifoInReady;
                endcase
            end
            else if (sclFall && ackSlot_reg)
                ackDrive_reg <= 1'b0;
        end
    end

    // Control byte and pointer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg <= `LCD_CTRL_RESET;
            ptr_reg <= 6'h00;
        end
        else if (clkEn && sclRise && !ackSlot_reg && bitCnt_reg == 4'h7)
        begin
            if (phase_reg == lcd_seg_pkg::PH_CTRL)
            begin
                ctrl_reg <= byteNext;
                ptr_reg <= byteNext[`LCD_CTRL_PTR_MSB:0];
            end
            else if (phase_reg == lcd_seg_pkg::PH_DATA && (fifoInReady || !ptrMatch))
            begin
                // step and wrap; advance even unmatched
                ptr_reg <= ptr_reg + (ctrl_reg[`LCD_CTRL_MODE_BIT] ?
                           `LCD_STEP_DUPLEX : `LCD_STEP_DIRECT);
            end
        end
    end

    // Completed data byte pushed toward the register file
    assign fifoInValid = clkEn && sclRise && !ackSlot_reg && bitCnt_reg == 4'h7 &&
                         phase_reg == lcd_seg_pkg::PH_DATA && ptrMatch;
    assign fifoInData = {ptr_reg[5:0], byteNext};

    lcd_seg_fifo #(
        .WIDTH(14),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .ce(clkEn),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(1'b1),
        .outData(fifoOutData)
    );

    assign wrIndex = fifoOutData[10:8];

    // segment registers cleared; written only by data bytes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 8; i++)
                segReg_reg[i] <= `LCD_SEG_RESET;
        end
        else if (clkEn && fifoOutValid)
            segReg_reg[wrIndex] <= fifoOutData[7:0];
    end

    // ack pulls SDA low; never transmits data
    assign sdaOut = 1'b0;
    assign sdaOe = ackSlot_reg && ackDrive_reg;

    // Segment and backplane drive; backplanes keep their reset low level
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            segmentOutputs <= '0;
            firstBackplane <= 1'b0;
            secondBackplane <= 1'b0;
        end
        else if (clkEn)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (ctrl_reg[`LCD_CTRL_MODE_BIT])
                    // duplex: both banks shown, combined per pin
                    segmentOutputs[8*k+1 +: 8] <= segReg_reg[2*k] | segReg_reg[2*k+1];
                else
                    segmentOutputs[8*k+1 +: 8] <= ctrl_reg[`LCD_CTRL_BANK_BIT] ?
                                                  segReg_reg[2*k+1] : segReg_reg[2*k];
            end
        end
    end

    // backplanes floated in cascade; second only in duplex
    assign firstBackplaneOe = !cascadeMode;
    assign secondBackplaneOe = !cascadeMode && ctrl_reg[`LCD_CTRL_MODE_BIT];

    // Status outputs
    assign driveMode = ctrl_reg[`LCD_CTRL_MODE_BIT];
    assign bankSelect = ctrl_reg[`LCD_CTRL_BANK_BIT];
    assign segmentBytePointer = ptr_reg;
    assign busBusy = (phase_reg != lcd_seg_pkg::PH_IDLE);
endmodule

// ==== verilog/lcd_seg_params.svh ====
// Constants for the two-wire LCD segment driver slave.
// Assumes it is included by bare name from the design file.
`ifndef LCD_SEG_PARAMS_SVH
`define LCD_SEG_PARAMS_SVH
// Fixed write address byte, direction bit included
`define LCD_SLAVE_ADDR 8'h74
// Control byte field positions
`define LCD_CTRL_MODE_BIT 7
`define LCD_CTRL_BANK_BIT 6
`define LCD_CTRL_PTR_MSB 5
// Reset values
`define LCD_CTRL_RESET 8'h00
`define LCD_SEG_RESET 8'h00
// Pointer steps per stored byte
`define LCD_STEP_DIRECT 6'h02
`define LCD_STEP_DUPLEX 6'h01
// Bits per byte, ack slot index
`define LCD_BITS_PER_BYTE 4'h8
`endif

// ==== verilog/lcd_seg_pkg.sv ====
// Types shared by the LCD segment driver slave.
// Assumes no other package.
package lcd_seg_pkg;
    // Byte phase within a transfer
    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_CTRL, PH_DATA} phase_t;
endpackage

// ==== verilog/lcd_seg_fifo.sv ====
// Small synchronous FIFO for received segment bytes.
// Assumes one clock, active-low synchronous-released reset.
`timescale 1ns/10ps
module lcd_seg_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    // Storage array
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;

    assign inReady = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWr = ce && inValid && inReady;
    assign doRd = ce && outValid && outReady;

    // Data storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (doWr)
            mem[wrPtr_reg] <= inData;
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (doWr)
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            if (doRd)
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            if (doWr && !doRd)
                count_reg <= count_reg + 1'b1;
            else if (doRd && !doWr)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// ==== tb/lcd_seg_slave_sva.sv ====
// Port checker for the two-wire LCD segment slave.
// Assumes it is bound to every lcd_seg_slave instance.
`timescale 1ns/10ps
module lcd_seg_slave_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [2:0] hardwareSubaddressPins,
    input wire logic cascadeMode,
    input wire logic [32:1] segmentOutputs,
    input wire logic firstBackplane,
    input wire logic firstBackplaneOe,
    input wire logic secondBackplane,
    input wire logic secondBackplaneOe,
    input wire logic driveMode,
    input wire logic bankSelect,
    input wire logic [5:0] segmentBytePointer,
    input wire logic busBusy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_sda_low; sdaOut == 1'b0; endproperty
    property p_bp_low; !firstBackplane && !secondBackplane; endproperty
    property p_bp1_oe; firstBackplaneOe == !cascadeMode; endproperty
    property p_bp2_oe; secondBackplaneOe == (!cascadeMode && driveMode); endproperty
    property p_idle_quiet; !busBusy |-> !sdaOe; endproperty
    property p_ack_scl_low; $rose(sdaOe) |-> !sclIn; endproperty
    property p_ack_stands; $rose(sdaOe) |-> sdaOe [*6]; endproperty
    property p_ptr_busy; $changed(segmentBytePointer) |-> $past(busBusy); endproperty
    property p_ctrl_idle;
        !busBusy && !$past(busBusy) |-> $stable({driveMode, bankSelect});
    endproperty
    property p_seg_idle;
        !busBusy && !$past(busBusy, 4) |-> $stable(segmentOutputs);
    endproperty
    // Open drain only pulls low
    a_sda_low: assert property (p_sda_low) else $error("sda driven high");
    // Backplanes held low
    a_bp_low: assert property (p_bp_low) else $error("backplane not low");
    // First backplane float when cascaded
    a_bp1_oe: assert property (p_bp1_oe) else $error("bp1 enable wrong");
    // Second backplane duplex only
    a_bp2_oe: assert property (p_bp2_oe) else $error("bp2 enable wrong");
    // No ack off bus
    a_idle_quiet: assert property (p_idle_quiet) else $error("ack while idle");
    // Ack set up low
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("ack with scl high");
    // Ack holds pulse
    a_ack_stands: assert property (p_ack_stands) else $error("ack too short");
    // Pointer frozen idle
    a_ptr_busy: assert property (p_ptr_busy) else $error("pointer moved idle");
    // Control frozen idle
    a_ctrl_idle: assert property (p_ctrl_idle) else $error("control moved idle");
    // Segments frozen idle
    a_seg_idle: assert property (p_seg_idle) else $error("segments moved idle");
    c_ack: cover property ($rose(sdaOe));
    c_duplex: cover property ($rose(driveMode));
    c_wrap: cover property ($past(segmentBytePointer[5]) && !segmentBytePointer[5]);
    c_cascade: cover property ($rose(cascadeMode));
endmodule
bind lcd_seg_slave lcd_seg_slave_sva chk (.*);

// ==== tb/lcd_i2c_master.sv ====
// Two-wire bus master model writing display bytes.
// Assumes a pull-up resolves sdaIn; all changes land on falling clk.
`timescale 1ns/10ps
module lcd_i2c_master (
    input wire logic clk,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sdaLow,
    output logic ackStrobe,
    output logic ackSeen
);
    initial
    begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
        ackStrobe = 1'b0;
        ackSeen = 1'b0;
    end
    task automatic waitN(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic startCond();
        waitN(3);
        sdaLow = 1'b1;
        waitN(3);
        sclOut = 1'b0;
    endtask
    // Data moves low only; long low phase lets ack settle before rise
    task automatic bitCycle(input logic b, output logic seen);
        waitN(2);
        sdaLow = !b;
        waitN(3);
        sclOut = 1'b1;
        waitN(3);
        seen = sdaIn;
        sclOut = 1'b0;
    endtask
    task automatic sendByte(input logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--)
            bitCycle(b[i], seen);
        bitCycle(1'b1, seen);
        ackSeen = !seen;
        ackStrobe = 1'b1;
        waitN(1);
        ackStrobe = 1'b0;
    endtask
    task automatic stopCond();
        waitN(2);
        sdaLow = 1'b1;
        waitN(3);
        sclOut = 1'b1;
        waitN(3);
        sdaLow = 1'b0;
        waitN(3);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the LCD segment slave.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/10ps
`include "lcd_seg_params.svh"
module testbench;
    logic clk, resetn, clkEn, cascadeMode, segStrobe, sdaWire;
    logic sclOut, sdaLow, ackStrobe, ackSeen, sdaOut, sdaOe;
    logic bp1, bp1Oe, bp2, bp2Oe, driveMode, bankSelect, busBusy;
    logic [2:0] pins;
    logic [32:1] segmentOutputs;
    logic [5:0] segmentBytePointer, ptr;
    logic [7:0] regs [8];
    logic mode, bank;
    logic ackQ [$];
    logic [47:0] segQ [$];
    int seed = 32'hd274;
    int error_cnt = 0;
    int num_checks = 0;
    // Pull-up on the shared data wire
    assign sdaWire = !(sdaLow || sdaOe);
    lcd_i2c_master m (.clk(clk), .sdaIn(sdaWire), .sclOut(sclOut), .sdaLow(sdaLow),
        .ackStrobe(ackStrobe), .ackSeen(ackSeen));
    lcd_seg_slave #(.FIFO_DEPTH(16)) dut (.clk(clk), .resetn(resetn), .clkEn(clkEn),
        .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .hardwareSubaddressPins(pins), .cascadeMode(cascadeMode),
        .segmentOutputs(segmentOutputs), .firstBackplane(bp1), .firstBackplaneOe(bp1Oe),
        .secondBackplane(bp2), .secondBackplaneOe(bp2Oe), .driveMode(driveMode),
        .bankSelect(bankSelect), .segmentBytePointer(segmentBytePointer),
        .busBusy(busBusy));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask
    task automatic note();
        logic [31:0] s;
        for (int k = 0; k < 4; k++)
            s[8*k +: 8] = mode ? (regs[2*k] | regs[2*k+1]) : regs[2*k + bank];
        segQ.push_back({3'h0, 3'h0, !cascadeMode, !cascadeMode && mode, ptr, mode, bank, s});
        segStrobe = 1'b1;
        @(negedge clk);
        segStrobe = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] addrByte, input logic [7:0] ctrl, input int n);
        logic [7:0] d;
        logic hit;
        m.startCond();
        ackQ.push_back(addrByte == `LCD_SLAVE_ADDR);
        m.sendByte(addrByte);
        if (addrByte == `LCD_SLAVE_ADDR)
        begin
            ackQ.push_back(1'b1);
            m.sendByte(ctrl);
            mode = ctrl[`LCD_CTRL_MODE_BIT];
            bank = ctrl[`LCD_CTRL_BANK_BIT];
            ptr = ctrl[5:0];
            for (int i = 0; i < n; i++)
            begin
                d = 8'($random(seed));
                hit = mode ? (ptr[4:3] == pins[1:0]) : (ptr[5:3] == pins);
                ackQ.push_back(hit);
                m.sendByte(d);
                if (hit)
                    regs[ptr[2:0]] = d;
                ptr = ptr + (mode ? `LCD_STEP_DUPLEX : `LCD_STEP_DIRECT);
            end
        end
        m.stopCond();
        repeat (10) @(negedge clk);
        note();
    endtask
    // Oldest note against each result
    always @(posedge clk)
    begin
        if (ackStrobe === 1'b1)
            check({47'h0, ackSeen}, {47'h0, ackQ.size() > 0 ? ackQ.pop_front() : 1'bx});
        if (segStrobe === 1'b1)
            check({3'h0, sdaOut, bp1, bp2, bp1Oe, bp2Oe, segmentBytePointer, driveMode,
                bankSelect, segmentOutputs}, segQ.size() > 0 ? segQ.pop_front() : 48'hx);
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    initial
    begin
        clkEn = 1'b1;
        cascadeMode = 1'b0;
        pins = 3'h7;
        resetn = 1'b0;
        segStrobe = 1'b0;
        mode = 1'b0;
        bank = 1'b0;
        ptr = 6'h00;
        for (int i = 0; i < 8; i++)
            regs[i] = `LCD_SEG_RESET;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        note();
        xfer(8'h76, 8'h00, 0);
        xfer(8'h74, 8'h38, 5);
        xfer(8'h74, 8'h79, 4);
        xfer(8'h74, 8'h00, 0);
        // Duplex, bank ignored; top pin differs yet selected
        pins = 3'h3;
        xfer(8'h74, 8'hfe, 4);
        cascadeMode = 1'b1;
        repeat (10) @(negedge clk);
        note();
        cascadeMode = 1'b0;
        for (int i = 0; i < 100 && ackQ.size() + segQ.size() > 0; i++)
            @(negedge clk);
        if (ackQ.size() + segQ.size() > 0)
            error_cnt++;
        conclude();
    end
endmodule
